// *** dv/ocd_prog_mem.sv ***
// Program memory model feeding opcode and operand bytes
`timescale 1ns/10ps
module ocd_prog_mem (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // Byte stream
  input  wire logic       op_ready,
  output      logic       op_valid = 1'b0,
  output      logic [7:0] op_byte = 8'h00,
  // Stall control
  input  wire logic       slow
);
  logic [7:0] q[$];
  logic [7:0] last;
  always @(posedge clk_sys) begin
    if (!resetn) begin
      op_valid <= 1'b0;
      last = 8'h00;
    end else if (!(op_valid && !op_ready)) begin
      if (op_valid) last = q.pop_front();
      if (q.size() != 0 && !(slow && $urandom_range(1, 0) == 0)) begin
        op_valid <= 1'b1;
        op_byte  <= q[0];
      end else begin
        op_valid <= 1'b0;
        op_byte  <= ~last;
      end
    end
  end
endmodule

// *** dv/opcode_length_cycle_decoder_bench.sv ***
// Self-checking bench for the opcode length and cycle decoder
`timescale 1ns/10ps
module opcode_length_cycle_decoder_bench;
  import ocd_pkg::*;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic       slow = 1'b0;
  logic       op_valid, op_ready, dec_valid, dec_known, dec_reg_vld, dec_ptr_sel;
  logic       dec_ptr_vld, opnd_valid, exec_done, busy;
  logic [7:0] op_byte, dec_opcode, opnd_byte, cur_op;
  logic [2:0] dec_cycles, dec_reg_sel;
  logic [1:0] dec_len, opnd_index;
  ocd_class_t dec_class;
  ocd_dec_t   e;
  logic [7:0] eq[$];
  int         errors, samples_checked, cyc_n, sent, done_n, left, idx, last_take, phase;
  always #2.5 clk_sys = ~clk_sys;
  ocd_decoder dut (.clk_sys(clk_sys), .resetn(resetn), .op_valid(op_valid), .op_byte(op_byte),
    .op_ready(op_ready), .dec_valid(dec_valid), .dec_opcode(dec_opcode), .dec_class(dec_class),
    .dec_len(dec_len), .dec_cycles(dec_cycles), .dec_known(dec_known), .dec_reg_sel(dec_reg_sel),
    .dec_reg_vld(dec_reg_vld), .dec_ptr_sel(dec_ptr_sel), .dec_ptr_vld(dec_ptr_vld),
    .opnd_valid(opnd_valid), .opnd_byte(opnd_byte), .opnd_index(opnd_index),
    .exec_done(exec_done), .busy(busy));
  ocd_prog_mem mem (.clk_sys(clk_sys), .resetn(resetn), .op_ready(op_ready), .op_valid(op_valid),
    .op_byte(op_byte), .slow(slow));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic ocd_dec_t m(ocd_class_t c, logic [1:0] l, logic [2:0] y, ocd_span_t s = SP_NO);
    return {c, s, l, y, 1'b1};
  endfunction
  // Reference decode of the documented opcodes
  function automatic ocd_dec_t xd(input logic [7:0] o);
    case (o) inside
      [8'h28:8'h2f]: return m(CL_ADD, L1, C1, SP_R8);
      8'h26, 8'h27: return m(CL_ADD, L1, C1, SP_P2);
      8'h24, 8'h25: return m(CL_ADD, L2, C1);
      [8'h38:8'h3f]: return m(CL_ADD_CARRY, L1, C1, SP_R8);
      8'h34, 8'h35: return m(CL_ADD_CARRY, L2, C1);
      [8'h98:8'h9f]: return m(CL_SUB_BORROW, L1, C1, SP_R8);
      8'h94, 8'h95: return m(CL_SUB_BORROW, L2, C1);
      [8'h58:8'h5f]: return m(CL_AND, L1, C1, SP_R8);
      8'h52: return m(CL_AND, L2, C1);
      8'h53: return m(CL_AND, L3, C2);
      [8'h48:8'h4f]: return m(CL_OR, L1, C1, SP_R8);
      8'h42: return m(CL_OR, L2, C1);
      8'h43: return m(CL_OR, L3, C2);
      [8'h68:8'h6f]: return m(CL_XOR, L1, C1, SP_R8);
      8'h62: return m(CL_XOR, L2, C1);
      8'h63: return m(CL_XOR, L3, C2);
      8'h23: return m(CL_ROT_L, L1, C1);
      8'h33: return m(CL_ROT_LC, L1, C1);
      8'h03: return m(CL_ROT_R, L1, C1);
      8'h13: return m(CL_ROT_RC, L1, C1);
      [8'h88:8'h8f], [8'ha8:8'haf]: return m(CL_MOVE, L2, C2, SP_R8);
      8'h85: return m(CL_MOVE, L3, C2);
      8'h90: return m(CL_LOAD_DP, L3, C2);
      8'h93: return m(CL_CODE_LOAD, L1, C2);
      8'he0, 8'hf0: return m(CL_EXT_MOVE, L1, C2);
      8'he2, 8'he3: return m(CL_EXT_MOVE, L1, C2, SP_P2);
      8'hd0: return m(CL_POP, L2, C2);
      8'hd6, 8'hd7: return m(CL_NIBBLE_XCHG, L1, C1, SP_P2);
      8'h82, 8'hb0: return m(CL_BIT_AND, L2, C2);
      8'h92: return m(CL_BIT_MOVE, L2, C2);
      8'h02: return m(CL_LONG_JUMP, L3, C2);
      8'h22: return m(CL_RET, L1, C2);
      8'h32: return m(CL_INT_RET, L1, C2);
      8'h10: return m(CL_BIT_JUMP_CLR, L3, C2);
      [8'hb8:8'hbf]: return m(CL_CMP_JUMP, L3, C2, SP_R8);
      [8'hd8:8'hdf]: return m(CL_DEC_JUMP, L2, C2, SP_R8);
      8'h73: return m(CL_IND_JUMP, L1, C2);
      default: return DEC_UNKNOWN;
    endcase
  endfunction
  // Reference sequencing: opcode, operands, then execution
  always @(posedge clk_sys) begin
    cyc_n++;
    if (resetn) begin
      if (exec_done) begin
        chk("exec_cycles", 16'(cyc_n - last_take), 16'(e.cyc));
        done_n++;
        phase = 0;
      end
      if (dec_valid) begin
        chk("opcode", dec_opcode, cur_op);
        chk("busy", busy, 16'h0001);
        chk("class", dec_class, e.cls);
        chk("length", dec_len, e.len);
        chk("cycles", dec_cycles, e.cyc);
        chk("known", dec_known, e.known);
        chk("reg_vld", dec_reg_vld, e.span == SP_R8);
        chk("ptr_vld", dec_ptr_vld, e.span == SP_P2);
        if (e.span == SP_R8) chk("reg_sel", dec_reg_sel, cur_op[2:0]);
        if (e.span == SP_P2) chk("ptr_sel", dec_ptr_sel, cur_op[0]);
      end
      if (opnd_valid) begin
        idx++;
        chk("opnd_byte", opnd_byte, eq.pop_front());
        chk("opnd_index", opnd_index, 16'(idx));
      end
      if (op_valid && op_ready) begin
        chk("take_in_exec", 16'(phase == 2), 16'h0000);
        if (phase == 0) begin
          cur_op = op_byte;
          e = xd(op_byte);
          left = e.len - 1;
          idx = 0;
        end else begin
          eq.push_back(op_byte);
          left--;
        end
        phase = (left == 0) ? 2 : 1;
        if (left == 0) last_take = cyc_n;
      end
    end
  end
  task automatic run_test(input string nm, input logic s, input logic rnd);
    int n;
    logic [7:0] o;
    ocd_dec_t d;
    @(negedge clk_sys);
    slow <= s;
    for (int i = 0; i < 256; i++) begin
      o = rnd ? 8'($urandom_range(255, 0)) : 8'(i);
      d = xd(o);
      if (d.known || o == 8'ha5) begin
        mem.q.push_back(o);
        for (int j = 1; j < d.len; j++) mem.q.push_back(8'($urandom));
        sent++;
      end
    end
    for (n = 0; n < 20000 && done_n != sent; n++) @(posedge clk_sys);
    if (n == 20000) begin
      errors++;
      $display("Timeout waiting in %s", nm);
      complete_run();
    end
    $display("Test %s done", nm);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h5656));
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("rst_class", dec_class, CL_UNKNOWN);
    chk("rst_len", dec_len, L1);
    chk("rst_ready_busy", {op_ready, busy, dec_valid}, 3'h4);
    @(posedge clk_sys);
    resetn <= 1'b1;
    run_test("table_sweep", 1'b0, 1'b0);
    run_test("stalled_sweep", 1'b1, 1'b0);
    run_test("random_mix", 1'b1, 1'b1);
    complete_run();
  end
endmodule

// *** src/ocd_dec_if.sv ***
// Interface between the decoder top, its operand selector and its sequencer
`timescale 1ns/10ps
interface ocd_dec_if;
  import ocd_pkg::*;
  logic [7:0] opcode;
  ocd_span_t  span;
  logic [2:0] reg_sel;
  logic       reg_vld;
  logic       ptr_sel;
  logic       ptr_vld;
  logic [1:0] len;
  logic [2:0] cyc;
  logic       take;
  logic       at_opcode;
  logic       opnd_take;
  logic       op_ready;
  logic       exec_done;
  logic       busy;

  modport dec (output opcode, span, len, cyc, take,
               input  reg_sel, reg_vld, ptr_sel, ptr_vld, at_opcode, opnd_take, op_ready, exec_done, busy);
  modport sel (input opcode, span, output reg_sel, reg_vld, ptr_sel, ptr_vld);
  modport seq (input len, cyc, take, output at_opcode, opnd_take, op_ready, exec_done, busy);
endinterface

// *** src/ocd_decoder.sv ***
// Opcode decoder giving class, length and cycle count, with operand fetch sequencing
`timescale 1ns/10ps
// How it works
// RULE_01 - Add opcodes: register, direct, indirect, immediate
// RULE_02 - Add with carry decodes like plain add
// RULE_03 - Subtract with borrow: register, direct, immediate forms
// RULE_04 - AND forms; immediate into direct three bytes
// RULE_05 - OR forms; immediate into direct three bytes
// RULE_06 - XOR forms; immediate into direct three bytes
// RULE_07 - Four accumulator rotates, one byte, one cycle
// RULE_08 - Register/direct moves are two bytes, two cycles
// RULE_09 - Direct to direct move: three bytes, two cycles
// RULE_10 - Data pointer immediate load: three bytes, two cycles
// RULE_11 - Code byte load: one byte, two cycles
// RULE_12 - External data moves: one byte, two cycles
// RULE_13 - Stack pop to direct: two bytes, two cycles
// RULE_14 - Nibble exchange: one byte, one cycle
// RULE_15 - Bit AND into carry, plain and inverted
// RULE_16 - Carry to bit: two bytes, two cycles
// RULE_17 - Long jump: three bytes, two cycles
// RULE_18 - Both returns: one byte, two cycles
// RULE_19 - Bit test branch clear: three bytes, two cycles
// RULE_20 - Compare register branch unequal: three bytes, two cycles
// RULE_21 - Decrement register branch nonzero: two bytes, two cycles
// RULE_22 - Indirect jump via data pointer: one byte
// RULE_23 - Low opcode bits select register or pointer
// RULE_24 - Output length and cycles for every opcode
module ocd_decoder (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  // Program memory byte stream
  input  wire logic               op_valid,
  input  wire logic [7:0]         op_byte,
  output wire logic               op_ready,
  // Decoded opcode
  output      logic               dec_valid,
  output      logic [7:0]         dec_opcode,
  output      ocd_pkg::ocd_class_t dec_class,
  output      logic [1:0]         dec_len,
  output      logic [2:0]         dec_cycles,
  output      logic               dec_known,
  output      logic [2:0]         dec_reg_sel,
  output      logic               dec_reg_vld,
  output      logic               dec_ptr_sel,
  output      logic               dec_ptr_vld,
  // Operand bytes
  output      logic               opnd_valid,
  output      logic [7:0]         opnd_byte,
  output      logic [1:0]         opnd_index,
  // Execution progress
  output wire logic               exec_done,
  output wire logic               busy
);
  import ocd_pkg::*;

  ocd_dec_if dif ();

  ocd_dec_t   next_dec;
  logic [1:0] opnd_num;
  logic       take;
  logic       op_take;

  assign take      = op_valid && dif.op_ready;
  assign op_take   = take && dif.at_opcode;
  assign op_ready  = dif.op_ready;
  assign exec_done = dif.exec_done;
  assign busy      = dif.busy;

  assign dif.opcode = op_byte;
  assign dif.span   = next_dec.span;
  assign dif.len    = next_dec.len;
  assign dif.cyc    = next_dec.cyc;
  assign dif.take   = take;

  ocd_opnd_sel u_sel (
    .dif (dif.sel)
  );

  ocd_seq u_seq (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .dif     (dif.seq)
  );

  // Decode table: class, operand span, length, cycles
  always_comb begin
    next_dec = DEC_UNKNOWN;
    casez (op_byte)
      8'b0010_1???: next_dec = ocd_mk(CL_ADD, SP_R8, L1, C1); // RULE_01
      8'h25:        next_dec = ocd_mk(CL_ADD, SP_NO, L2, C1); // RULE_01
      8'b0010_011?: next_dec = ocd_mk(CL_ADD, SP_P2, L1, C1); // RULE_01
      8'h24:        next_dec = ocd_mk(CL_ADD, SP_NO, L2, C1); // RULE_01
      8'b0011_1???: next_dec = ocd_mk(CL_ADD_CARRY, SP_R8, L1, C1); // RULE_02
      8'h35:        next_dec = ocd_mk(CL_ADD_CARRY, SP_NO, L2, C1); // RULE_02
      8'b0011_011?: next_dec = ocd_mk(CL_ADD_CARRY, SP_P2, L1, C1);
      8'h34:        next_dec = ocd_mk(CL_ADD_CARRY, SP_NO, L2, C1); // RULE_02
      8'b1001_1???: next_dec = ocd_mk(CL_SUB_BORROW, SP_R8, L1, C1); // RULE_03
      8'h95:        next_dec = ocd_mk(CL_SUB_BORROW, SP_NO, L2, C1); // RULE_03
      8'b1001_011?: next_dec = ocd_mk(CL_SUB_BORROW, SP_P2, L1, C1);
      8'h94:        next_dec = ocd_mk(CL_SUB_BORROW, SP_NO, L2, C1); // RULE_03
      8'h04:        next_dec = ocd_mk(CL_INC, SP_NO, L1, C1);
      8'b0000_1???: next_dec = ocd_mk(CL_INC, SP_R8, L1, C1);
      8'h05:        next_dec = ocd_mk(CL_INC, SP_NO, L2, C1);
      8'b0000_011?: next_dec = ocd_mk(CL_INC, SP_P2, L1, C1);
      8'h14:        next_dec = ocd_mk(CL_DEC, SP_NO, L1, C1);
      8'b0001_1???: next_dec = ocd_mk(CL_DEC, SP_R8, L1, C1);
      8'h15:        next_dec = ocd_mk(CL_DEC, SP_NO, L2, C1);
      8'b0001_011?: next_dec = ocd_mk(CL_DEC, SP_P2, L1, C1);
      8'ha3:        next_dec = ocd_mk(CL_INC_DP, SP_NO, L1, C2);
      8'ha4:        next_dec = ocd_mk(CL_MUL, SP_NO, L1, C4);
      8'h84:        next_dec = ocd_mk(CL_DIV, SP_NO, L1, C4);
      8'hd4:        next_dec = ocd_mk(CL_DEC_ADJ, SP_NO, L1, C1);
      8'b0101_1???: next_dec = ocd_mk(CL_AND, SP_R8, L1, C1); // RULE_04
      8'h55:        next_dec = ocd_mk(CL_AND, SP_NO, L2, C1);
      8'b0101_011?: next_dec = ocd_mk(CL_AND, SP_P2, L1, C1);
      8'h54:        next_dec = ocd_mk(CL_AND, SP_NO, L2, C1);
      8'h52:        next_dec = ocd_mk(CL_AND, SP_NO, L2, C1); // RULE_04
      8'h53:        next_dec = ocd_mk(CL_AND, SP_NO, L3, C2); // RULE_04
      8'b0100_1???: next_dec = ocd_mk(CL_OR, SP_R8, L1, C1); // RULE_05
      8'h45:        next_dec = ocd_mk(CL_OR, SP_NO, L2, C1);
      8'b0100_011?: next_dec = ocd_mk(CL_OR, SP_P2, L1, C1);
      8'h44:        next_dec = ocd_mk(CL_OR, SP_NO, L2, C1);
      8'h42:        next_dec = ocd_mk(CL_OR, SP_NO, L2, C1); // RULE_05
      8'h43:        next_dec = ocd_mk(CL_OR, SP_NO, L3, C2); // RULE_05
      8'b0110_1???: next_dec = ocd_mk(CL_XOR, SP_R8, L1, C1); // RULE_06
      8'h65:        next_dec = ocd_mk(CL_XOR, SP_NO, L2, C1);
      8'b0110_011?: next_dec = ocd_mk(CL_XOR, SP_P2, L1, C1);
      8'h64:        next_dec = ocd_mk(CL_XOR, SP_NO, L2, C1);
      8'h62:        next_dec = ocd_mk(CL_XOR, SP_NO, L2, C1); // RULE_06
      8'h63:        next_dec = ocd_mk(CL_XOR, SP_NO, L3, C2); // RULE_06
      8'he4:        next_dec = ocd_mk(CL_CLR_ACC, SP_NO, L1, C1);
      8'hf4:        next_dec = ocd_mk(CL_CPL_ACC, SP_NO, L1, C1);
      8'hc4:        next_dec = ocd_mk(CL_SWAP, SP_NO, L1, C1);
      8'h23:        next_dec = ocd_mk(CL_ROT_L, SP_NO, L1, C1); // RULE_07
      8'h33:        next_dec = ocd_mk(CL_ROT_LC, SP_NO, L1, C1); // RULE_07
      8'h03:        next_dec = ocd_mk(CL_ROT_R, SP_NO, L1, C1); // RULE_07
      8'h13:        next_dec = ocd_mk(CL_ROT_RC, SP_NO, L1, C1); // RULE_07
      8'b1110_1???: next_dec = ocd_mk(CL_MOVE, SP_R8, L1, C1);
      8'he5:        next_dec = ocd_mk(CL_MOVE, SP_NO, L2, C1);
      8'b1110_011?: next_dec = ocd_mk(CL_MOVE, SP_P2, L1, C1);
      8'h74:        next_dec = ocd_mk(CL_MOVE, SP_NO, L2, C1);
      8'b1111_1???: next_dec = ocd_mk(CL_MOVE, SP_R8, L1, C1);
      8'b1010_1???: next_dec = ocd_mk(CL_MOVE, SP_R8, L2, C2); // RULE_08
      8'b0111_1???: next_dec = ocd_mk(CL_MOVE, SP_R8, L2, C1);
      8'hf5:        next_dec = ocd_mk(CL_MOVE, SP_NO, L2, C1);
      8'b1000_1???: next_dec = ocd_mk(CL_MOVE, SP_R8, L2, C2); // RULE_08
      8'h85:        next_dec = ocd_mk(CL_MOVE, SP_NO, L3, C2); // RULE_09
      8'b1000_011?: next_dec = ocd_mk(CL_MOVE, SP_P2, L2, C2);
      8'h75:        next_dec = ocd_mk(CL_MOVE, SP_NO, L3, C2);
      8'b1111_011?: next_dec = ocd_mk(CL_MOVE, SP_P2, L1, C1);
      8'b1010_011?: next_dec = ocd_mk(CL_MOVE, SP_P2, L2, C2);
      8'b0111_011?: next_dec = ocd_mk(CL_MOVE, SP_P2, L2, C1);
      8'h90:        next_dec = ocd_mk(CL_LOAD_DP, SP_NO, L3, C2); // RULE_10
      8'h93:        next_dec = ocd_mk(CL_CODE_LOAD, SP_NO, L1, C2); // RULE_11
      8'b1110_001?: next_dec = ocd_mk(CL_EXT_MOVE, SP_P2, L1, C2); // RULE_12
      8'he0:        next_dec = ocd_mk(CL_EXT_MOVE, SP_NO, L1, C2); // RULE_12
      8'b1111_001?: next_dec = ocd_mk(CL_EXT_MOVE, SP_P2, L1, C2);
      8'hf0:        next_dec = ocd_mk(CL_EXT_MOVE, SP_NO, L1, C2); // RULE_12
      8'hc0:        next_dec = ocd_mk(CL_PUSH, SP_NO, L2, C2);
      8'hd0:        next_dec = ocd_mk(CL_POP, SP_NO, L2, C2); // RULE_13
      8'b1100_1???: next_dec = ocd_mk(CL_XCHG, SP_R8, L1, C1);
      8'hc5:        next_dec = ocd_mk(CL_XCHG, SP_NO, L2, C1);
      8'b1100_011?: next_dec = ocd_mk(CL_XCHG, SP_P2, L1, C1);
      8'b1101_011?: next_dec = ocd_mk(CL_NIBBLE_XCHG, SP_P2, L1, C1); // RULE_14
      8'hc3:        next_dec = ocd_mk(CL_BIT_CLR, SP_NO, L1, C1);
      8'hc2:        next_dec = ocd_mk(CL_BIT_CLR, SP_NO, L2, C1);
      8'hd3:        next_dec = ocd_mk(CL_BIT_SET, SP_NO, L1, C1);
      8'hd2:        next_dec = ocd_mk(CL_BIT_SET, SP_NO, L2, C1);
      8'hb3:        next_dec = ocd_mk(CL_BIT_CPL, SP_NO, L1, C1);
      8'hb2:        next_dec = ocd_mk(CL_BIT_CPL, SP_NO, L2, C1);
      8'h82:        next_dec = ocd_mk(CL_BIT_AND, SP_NO, L2, C2); // RULE_15
      8'hb0:        next_dec = ocd_mk(CL_BIT_AND, SP_NO, L2, C2); // RULE_15
      8'h72:        next_dec = ocd_mk(CL_BIT_OR, SP_NO, L2, C2);
      8'ha0:        next_dec = ocd_mk(CL_BIT_OR, SP_NO, L2, C2);
      8'ha2:        next_dec = ocd_mk(CL_BIT_MOVE, SP_NO, L2, C1);
      8'h92:        next_dec = ocd_mk(CL_BIT_MOVE, SP_NO, L2, C2); // RULE_16
      8'h22:        next_dec = ocd_mk(CL_RET, SP_NO, L1, C2); // RULE_18
      8'h32:        next_dec = ocd_mk(CL_INT_RET, SP_NO, L1, C2); // RULE_18
      8'h02:        next_dec = ocd_mk(CL_LONG_JUMP, SP_NO, L3, C2); // RULE_17
      8'h80:        next_dec = ocd_mk(CL_SHORT_JUMP, SP_NO, L2, C2);
      8'h40:        next_dec = ocd_mk(CL_COND_JUMP, SP_NO, L2, C2);
      8'h50:        next_dec = ocd_mk(CL_COND_JUMP, SP_NO, L2, C2);
      8'h60:        next_dec = ocd_mk(CL_COND_JUMP, SP_NO, L2, C2);
      8'h70:        next_dec = ocd_mk(CL_COND_JUMP, SP_NO, L2, C2);
      8'h20:        next_dec = ocd_mk(CL_BIT_JUMP, SP_NO, L3, C2);
      8'h30:        next_dec = ocd_mk(CL_BIT_JUMP, SP_NO, L3, C2);
      8'h10:        next_dec = ocd_mk(CL_BIT_JUMP_CLR, SP_NO, L3, C2); // RULE_19
      8'h73:        next_dec = ocd_mk(CL_IND_JUMP, SP_NO, L1, C2); // RULE_22
      8'hb5:        next_dec = ocd_mk(CL_CMP_JUMP, SP_NO, L3, C2);
      8'hb4:        next_dec = ocd_mk(CL_CMP_JUMP, SP_NO, L3, C2);
      8'b1011_1???: next_dec = ocd_mk(CL_CMP_JUMP, SP_R8, L3, C2); // RULE_20
      8'b1011_011?: next_dec = ocd_mk(CL_CMP_JUMP, SP_P2, L3, C2);
      8'b1101_1???: next_dec = ocd_mk(CL_DEC_JUMP, SP_R8, L2, C2); // RULE_21
      8'hd5:        next_dec = ocd_mk(CL_DEC_JUMP, SP_NO, L3, C2);
      8'h00:        next_dec = ocd_mk(CL_NOP, SP_NO, L1, C1);
      default:      next_dec = DEC_UNKNOWN;
    endcase
  end

  // Decode strobe
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= op_take;
    end
  end

  // Decoded fields, held until the next opcode
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dec_opcode  <= OPC_RST;
      dec_class   <= DEC_UNKNOWN.cls;
      dec_len     <= DEC_UNKNOWN.len;
      dec_cycles  <= DEC_UNKNOWN.cyc;
      dec_known   <= 1'b0;
      dec_reg_sel <= SEL_RST;
      dec_reg_vld <= 1'b0;
      dec_ptr_sel <= 1'b0;
      dec_ptr_vld <= 1'b0;
    end else if (op_take) begin
      dec_opcode  <= op_byte;
      dec_class   <= next_dec.cls;
      dec_len     <= next_dec.len; // RULE_24
      dec_cycles  <= next_dec.cyc; // RULE_24
      dec_known   <= next_dec.known;
      dec_reg_sel <= dif.reg_sel; // RULE_23
      dec_reg_vld <= dif.reg_vld;
      dec_ptr_sel <= dif.ptr_sel; // RULE_23
      dec_ptr_vld <= dif.ptr_vld;
    end
  end

  // Operand byte capture
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      opnd_valid <= 1'b0;
      opnd_byte  <= OPC_RST;
      opnd_index <= IDX_RST;
      opnd_num   <= IDX_RST;
    end else begin
      opnd_valid <= dif.opnd_take; // RULE_24
      if (op_take) begin
        opnd_num <= IDX_RST;
      end else if (dif.opnd_take) begin
        opnd_byte  <= op_byte;
        opnd_index <= opnd_num + L1;
        opnd_num   <= opnd_num + L1;
      end
    end
  end

  // Checks
  AST_ADD_FORMS: assert property ( // RULE_01
    @(posedge clk_sys) disable iff (!resetn)
    op_take && (op_byte[7:3] == 5'b00101) |=> dec_class == CL_ADD && dec_len == L1 && dec_cycles == C1
  ) else $error("add register form decoded wrongly");

  AST_CARRY_DIRECT: assert property ( // RULE_02
    @(posedge clk_sys) disable iff (!resetn)
    dec_valid && dec_opcode == 8'h35 |-> dec_class == CL_ADD_CARRY && dec_len == L2 && dec_cycles == C1
  ) else $error("add with carry direct decoded wrongly");

  AST_BORROW_IMM: assert property ( // RULE_03
    @(posedge clk_sys) disable iff (!resetn)
    dec_valid && dec_class == CL_SUB_BORROW |-> dec_cycles == C1 && $past(op_byte) == dec_opcode
  ) else $error("subtract with borrow not single cycle");

  AST_LOGIC_IMM_DIRECT: assert property ( // RULE_04
    @(posedge clk_sys) disable iff (!resetn)
    op_take && (op_byte == 8'h53 || op_byte == 8'h43 || op_byte == 8'h63) |=> dec_len == L3 && dec_cycles == C2
  ) else $error("logic immediate into direct not three bytes two cycles");

  AST_ROTATES: assert property ( // RULE_07
    @(posedge clk_sys) disable iff (!resetn)
    op_take && (op_byte[3:0] == 4'h3) && !op_byte[7] && !op_byte[6] |=> dec_len == L1 && dec_cycles == C1
  ) else $error("rotate not one byte one cycle");

  AST_MOVE_REG_DIRECT: assert property ( // RULE_08
    @(posedge clk_sys) disable iff (!resetn)
    dec_valid && (dec_opcode[7:3] == 5'b10001 || dec_opcode[7:3] == 5'b10101)
      |-> dec_len == L2 && dec_cycles == C2 && dec_reg_vld && dec_reg_sel == dec_opcode[2:0]
  ) else $error("register direct move decoded wrongly");

  AST_EXT_MOVE: assert property ( // RULE_12
    @(posedge clk_sys) disable iff (!resetn)
    dec_valid && dec_class == CL_EXT_MOVE |-> dec_len == L1 && !exec_done ##1 exec_done
  ) else $error("external data move not two cycles");

  AST_POINTER_SELECT: assert property ( // RULE_23
    @(posedge clk_sys) disable iff (!resetn)
    op_take && (op_byte[7:1] == 7'b1101_011) |=> dec_ptr_vld && dec_ptr_sel == $past(op_byte[0]) && !dec_reg_vld
  ) else $error("indirect pointer select wrong");

  AST_LONG_JUMP_FETCH: assert property ( // RULE_17
    @(posedge clk_sys) disable iff (!resetn)
    dec_valid && dec_opcode == 8'h02 |-> busy && dec_len == L3 && !exec_done
  ) else $error("long jump not three bytes");

  AST_OPERAND_COUNT: assert property ( // RULE_24
    @(posedge clk_sys) disable iff (!resetn)
    opnd_valid |-> opnd_index < dec_len && opnd_index != IDX_RST
  ) else $error("operand index outside instruction length");

  AST_READY_IN_EXEC: assert property ( // RULE_24
    @(posedge clk_sys) disable iff (!resetn)
    exec_done |-> !op_ready ##1 !busy && op_ready
  ) else $error("sequencer did not return to opcode fetch");

  // Checks on return, branch and exchange forms
  AST_RETURNS: assert property ( // RULE_18
    @(posedge clk_sys) disable iff (!resetn)
    dec_valid && dec_opcode[7:5] == 3'h1 && dec_opcode[3:0] == 4'h2
      |-> dec_len == L1
      && dec_cycles == C2
  ) else $error("return form decoded wrongly");

  AST_CMP_BRANCH: assert property ( // RULE_20
    @(posedge clk_sys) disable iff (!resetn)
    dec_valid && dec_opcode[7:3] == 5'b10111
      |-> dec_len == L3
      && dec_cycles == C2
  ) else $error("compare branch decoded wrongly");

  AST_DEC_BRANCH: assert property ( // RULE_21
    @(posedge clk_sys) disable iff (!resetn)
    dec_valid && dec_opcode[7:3] == 5'b11011
      |-> dec_len == L2
      && dec_cycles == C2
  ) else $error("decrement branch decoded wrongly");

  AST_NIBBLE_XCHG: assert property ( // RULE_14
    @(posedge clk_sys) disable iff (!resetn)
    dec_valid && dec_opcode[7:1] == 7'b1101011
      |-> dec_len == L1
      && dec_cycles == C1
  ) else $error("nibble exchange decoded wrongly");

endmodule

// *** src/ocd_opnd_sel.sv ***
// Extracts working register and indirect pointer selects from the opcode
`timescale 1ns/10ps
module ocd_opnd_sel (
  // Decode link
  ocd_dec_if.sel dif
);
  import ocd_pkg::*;

  always_comb begin
    dif.reg_sel = dif.opcode[2:0]; // RULE_23
    dif.ptr_sel = dif.opcode[0]; // RULE_23
    dif.reg_vld = (dif.span == SP_R8); // RULE_23
    dif.ptr_vld = (dif.span == SP_P2); // RULE_23
  end

endmodule

// *** src/ocd_pkg.sv ***
// Shared constants, types and helpers for the opcode length and cycle decoder
package ocd_pkg;

  localparam int OPC_W = 8;

  // Instruction lengths in bytes
  localparam logic [1:0] L1 = 2'h1;
  localparam logic [1:0] L2 = 2'h2;
  localparam logic [1:0] L3 = 2'h3;

  // Execution times in machine cycles
  localparam logic [2:0] C1 = 3'h1;
  localparam logic [2:0] C2 = 3'h2;
  localparam logic [2:0] C4 = 3'h4;

  // Values after reset
  localparam logic [7:0] OPC_RST = 8'h00;
  localparam logic [1:0] REM_RST = 2'h0;
  localparam logic [2:0] CNT_RST = 3'h0;
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic [1:0] IDX_RST = 2'h0;

  // Operand field spans inside the opcode
  typedef enum logic [1:0] {SP_NO, SP_R8, SP_P2} ocd_span_t;

  typedef enum logic [5:0] {
    CL_ADD, CL_ADD_CARRY, CL_SUB_BORROW, CL_INC, CL_DEC, CL_INC_DP, CL_MUL, CL_DIV,
    CL_DEC_ADJ, CL_AND, CL_OR, CL_XOR, CL_CLR_ACC, CL_CPL_ACC, CL_SWAP, CL_ROT_L,
    CL_ROT_LC, CL_ROT_R, CL_ROT_RC, CL_MOVE, CL_LOAD_DP, CL_CODE_LOAD, CL_EXT_MOVE,
    CL_PUSH, CL_POP, CL_XCHG, CL_NIBBLE_XCHG, CL_BIT_CLR, CL_BIT_SET, CL_BIT_CPL,
    CL_BIT_AND, CL_BIT_OR, CL_BIT_MOVE, CL_RET, CL_INT_RET, CL_LONG_JUMP, CL_SHORT_JUMP,
    CL_COND_JUMP, CL_BIT_JUMP, CL_BIT_JUMP_CLR, CL_CMP_JUMP, CL_DEC_JUMP, CL_IND_JUMP,
    CL_NOP, CL_UNKNOWN
  } ocd_class_t;

  typedef struct packed {
    ocd_class_t cls;
    ocd_span_t  span;
    logic [1:0] len;
    logic [2:0] cyc;
    logic       known;
  } ocd_dec_t;

  localparam ocd_dec_t DEC_UNKNOWN = '{CL_UNKNOWN, SP_NO, L1, C1, 1'b0};

  // Builds one decode table entry for a recognised opcode
  function automatic ocd_dec_t ocd_mk(input ocd_class_t cls, input ocd_span_t span,
                                      input logic [1:0] len, input logic [2:0] cyc);
    ocd_dec_t d;
    d.cls   = cls;
    d.span  = span;
    d.len   = len;
    d.cyc   = cyc;
    d.known = 1'b1;
    return d;
  endfunction

endpackage

// *** src/ocd_seq.sv ***
// Sequences operand byte fetch and execution cycles for each decoded opcode
`timescale 1ns/10ps
module ocd_seq (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Decode link
  ocd_dec_if.seq   dif
);
  import ocd_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_OPND, ST_EXEC} ocd_seq_st_t;

  ocd_seq_st_t state;
  logic [1:0]  remain;
  logic [2:0]  cnt;

  assign dif.op_ready  = (state != ST_EXEC);
  assign dif.at_opcode = (state == ST_IDLE);
  assign dif.busy      = (state != ST_IDLE);
  assign dif.opnd_take = (state == ST_OPND) && dif.take; // RULE_24
  assign dif.exec_done = (state == ST_EXEC) && (cnt == C1); // RULE_24

  // Phase of the current instruction
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (dif.take) begin
            state <= (dif.len == L1) ? ST_EXEC : ST_OPND; // RULE_24
          end
        end
        ST_OPND: begin
          if (dif.take && remain == L1) begin
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (cnt == C1) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Operand bytes still to fetch
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      remain <= REM_RST;
    end else if (state == ST_IDLE && dif.take) begin
      remain <= dif.len - L1; // RULE_24
    end else if (dif.opnd_take) begin
      remain <= remain - L1;
    end
  end

  // Execution cycles left
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt <= CNT_RST;
    end else if (state == ST_IDLE && dif.take) begin
      cnt <= dif.cyc; // RULE_24
    end else if (state == ST_EXEC && cnt != C1) begin
      cnt <= cnt - C1;
    end
  end

endmodule
